// *** mqr_cfg.svh ***
`ifndef MQR_CFG_SVH
`define MQR_CFG_SVH

// apb register offsets (byte addresses)
`define MQR_OFS_CTRL 8'h00
`define MQR_OFS_STATUS 8'h04
`define MQR_OFS_WCOUNT 8'h08

// ctrl fields
`define MQR_CTRL_DIRECT_BIT 0
`define MQR_CTRL_RDEN_BIT 1
`define MQR_CTRL_RST_VAL 32'h0000_0003

// status fields
`define MQR_ST_SELQ_LSB 0
`define MQR_ST_RDQ_LSB 8
`define MQR_ST_OVN_BIT 16
`define MQR_ST_ACT_BIT 17
`define MQR_ST_LVL_LSB 20

// read address bus layout
`define MQR_ADDR_W 8
`define MQR_QSEL_W 5
`define MQR_DEVID_W 3
`define MQR_QUAD_W 2

// data and buffer
`define MQR_DATA_W 18
`define MQR_FIFO_DEPTH 8
`define MQR_NQUEUE 32
`define MQR_FLAG_W 8

// cycles from selection until the new queue feeds reads
`define MQR_SWITCH_CYC 2

`endif

// *** mqr_pkg.sv ***
package mqr_pkg;

    typedef enum logic [1:0] {
        SEL_IDLE = 2'b01,
        SEL_HOLD = 2'b10
    } mqr_sel_t;

    typedef logic [4:0] mqr_qidx_t;

endpackage : mqr_pkg

// *** mqr_sync.sv ***
`timescale 1ns/1ns
`default_nettype none

module mqr_sync #(
    parameter int WIDTH = 1
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    // first stage feeds only the second
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;

endmodule : mqr_sync

`default_nettype wire

// *** mqr_fifo.sv ***
`timescale 1ns/1ns
`default_nettype none

module mqr_fifo #(
    parameter int WIDTH = 18,
    parameter int DEPTH = 8
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_level
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_ff [DEPTH];
    logic [AW-1:0] wr_ptr_ff;
    logic [AW-1:0] rd_ptr_ff;
    logic [AW:0] cnt_ff;
    logic push;
    logic pop;

    assign o_in_ready = (cnt_ff < (AW+1)'(DEPTH));
    assign o_out_valid = (cnt_ff != '0);
    assign o_out_data = mem_ff[rd_ptr_ff];
    assign o_level = cnt_ff;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    function automatic logic [AW-1:0] ptr_inc(input logic [AW-1:0] p);
        ptr_inc = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction : ptr_inc

    always_ff @(posedge i_clk_sys) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= i_in_data;
        end
    end

    // full and empty come from one counter, so they cannot disagree
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
            cnt_ff <= '0;
        end else begin
            if (push) wr_ptr_ff <= ptr_inc(wr_ptr_ff);
            if (pop) rd_ptr_ff <= ptr_inc(rd_ptr_ff);
            cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

endmodule : mqr_fifo

`default_nettype wire

// *** mqr_read_port.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mqr_cfg.svh"

module mqr_read_port
    import mqr_pkg::*;
#(
    parameter int DATA_W = `MQR_DATA_W,
    parameter int FIFO_DEPTH = `MQR_FIFO_DEPTH
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    // controller pins
    input wire logic i_rd_addr_en,
    input wire logic [`MQR_ADDR_W-1:0] i_rd_queue_addr,
    input wire logic i_rd_en_n,
    input wire logic i_out_en_n,
    input wire logic i_almost_empty_strobe,
    input wire logic i_dev_select_bit0,
    input wire logic i_dev_select_bit1,
    input wire logic i_dev_select_bit2,
    output logic [DATA_W-1:0] o_rd_data,
    output logic o_rd_data_oe,
    output logic o_out_valid_n,
    output logic [`MQR_FLAG_W-1:0] o_almost_empty_flag_n,
    output logic o_almost_empty_flag_oe,
    // queue memory side, same clock
    input wire logic [`MQR_NQUEUE-1:0] i_queue_empty,
    input wire logic [`MQR_NQUEUE-1:0] i_queue_almost_empty,
    output logic o_mem_rd_req,
    output logic [`MQR_QSEL_W-1:0] o_mem_rd_queue,
    input wire logic i_mem_rd_valid,
    input wire logic [DATA_W-1:0] i_mem_rd_data,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    localparam int SW = 1 + `MQR_ADDR_W + 3 + `MQR_DEVID_W;

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers

    logic [SW-1:0] pin_async;
    logic [SW-1:0] pin_sync;
    logic s_addr_en;
    logic [`MQR_ADDR_W-1:0] s_addr;
    logic s_ren_n;
    logic s_oe_n;
    logic s_strobe;
    logic [`MQR_DEVID_W-1:0] s_id;

    assign pin_async = {i_rd_addr_en, i_rd_queue_addr, i_rd_en_n, i_out_en_n, i_almost_empty_strobe,
                        i_dev_select_bit2, i_dev_select_bit1, i_dev_select_bit0};
    assign {s_addr_en, s_addr, s_ren_n, s_oe_n, s_strobe, s_id} = pin_sync;

    mqr_sync #(.WIDTH(SW)) u_sync (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_async(pin_async),
        .o_sync(pin_sync)
    );

    ////////////////////////////////////////////////////////////////////////
    // apb register file

    logic [31:0] ctrl_ff;
    logic [31:0] wcount_ff;
    logic [31:0] prdata_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic apb_setup;
    logic apb_wr;
    logic hit_ctrl;
    logic hit_status;
    logic hit_wcount;
    logic hit_any;
    logic [31:0] status_w;
    logic [31:0] rd_mux;
    logic direct_mode;
    logic sw_rd_en;

    assign apb_setup = i_psel && !i_penable;
    assign apb_wr = i_psel && i_penable && pready_ff && i_pwrite;
    assign hit_ctrl = (i_paddr == `MQR_OFS_CTRL);
    assign hit_status = (i_paddr == `MQR_OFS_STATUS);
    assign hit_wcount = (i_paddr == `MQR_OFS_WCOUNT);
    assign hit_any = hit_ctrl || hit_status || hit_wcount;
    assign direct_mode = ctrl_ff[`MQR_CTRL_DIRECT_BIT];
    assign sw_rd_en = ctrl_ff[`MQR_CTRL_RDEN_BIT];
    assign rd_mux = hit_ctrl ? ctrl_ff : hit_status ? status_w : hit_wcount ? wcount_ff : 32'h0000_0000;

    // answer ready in the first access cycle; no wait states
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= 32'h0000_0000;
        end else begin
            pready_ff <= apb_setup;
            pslverr_ff <= apb_setup && !hit_any;
            if (apb_setup) prdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            ctrl_ff <= `MQR_CTRL_RST_VAL;
        end else if (apb_wr && hit_ctrl) begin
            ctrl_ff <= {30'h0000_0000, i_pwdata[1:0]};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // queue selection

    mqr_sel_t sel_st_ff;
    mqr_sel_t nxt_sel_st;
    mqr_qidx_t sel_q_ff;
    mqr_qidx_t rd_q_ff;
    logic sel_act_ff;
    logic rd_act_ff;
    logic id_match;
    logic sel_edge;

    assign id_match = (s_addr[`MQR_ADDR_W-1 -: `MQR_DEVID_W] == s_id);
    // a second choice inside the hold window is dropped
    assign sel_edge = s_addr_en && (sel_st_ff == SEL_IDLE);

    always_comb begin
        nxt_sel_st = sel_st_ff;
        unique case (sel_st_ff)
            SEL_IDLE: begin
                if (sel_edge) nxt_sel_st = SEL_HOLD;
            end
            SEL_HOLD: begin
                nxt_sel_st = SEL_IDLE;
            end
            default: begin
                nxt_sel_st = SEL_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            sel_st_ff <= SEL_IDLE;
            sel_q_ff <= 5'h00;
            sel_act_ff <= 1'b0;
            rd_q_ff <= 5'h00;
            rd_act_ff <= 1'b0;
        end else begin
            sel_st_ff <= nxt_sel_st;
            if (sel_edge) begin
                sel_q_ff <= s_addr[`MQR_QSEL_W-1:0];
                sel_act_ff <= id_match;
            end
            // old queue keeps feeding reads for the choosing edge and the next
            if (sel_st_ff == SEL_HOLD) begin
                rd_q_ff <= sel_q_ff;
                rd_act_ff <= sel_act_ff;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read issue towards queue memory

    logic mem_req_ff;
    logic [`MQR_QSEL_W-1:0] mem_q_ff;
    logic [LW-1:0] fifo_level;
    logic [LW:0] pending;
    logic room;
    logic rd_fire;

    // words in flight are counted so the buffer can never overflow
    assign pending = (LW+1)'(fifo_level) + (LW+1)'(mem_req_ff) + (LW+1)'(i_mem_rd_valid);
    assign room = (pending < (LW+1)'(FIFO_DEPTH));
    // an empty queue gives no reads, old queue reads keep going meanwhile
    assign rd_fire = !s_ren_n && sw_rd_en && rd_act_ff && !i_queue_empty[rd_q_ff] && room;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            mem_req_ff <= 1'b0;
            mem_q_ff <= 5'h00;
        end else begin
            mem_req_ff <= rd_fire;
            mem_q_ff <= rd_q_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // two-stage pipe: buffer then output register

    logic fifo_out_valid;
    logic [DATA_W-1:0] fifo_out_data;
    logic out_take;
    logic [DATA_W-1:0] rd_data_ff;
    logic ovn_ff;
    logic oe_ff;
    logic load_out;

    // output register takes a word when free or when the reader consumes it
    assign out_take = ovn_ff || !s_ren_n;
    assign load_out = out_take && fifo_out_valid;

    mqr_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_in_valid(i_mem_rd_valid),
        .o_in_ready(),
        .i_in_data(i_mem_rd_data),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(out_take),
        .o_out_data(fifo_out_data),
        .o_level(fifo_level)
    );

    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            rd_data_ff <= '0;
            ovn_ff <= 1'b1;
            oe_ff <= 1'b0;
            wcount_ff <= 32'h0000_0000;
        end else begin
            // old word kept when nothing follows, flagged stale
            if (load_out) rd_data_ff <= fifo_out_data;
            if (out_take) ovn_ff <= !fifo_out_valid;
            oe_ff <= !s_oe_n && rd_act_ff;
            if (load_out) wcount_ff <= wcount_ff + 32'h0000_0001;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // almost-empty flag bus

    logic [`MQR_QUAD_W-1:0] quad_ff;
    logic flag_oe_ff;
    logic [`MQR_FLAG_W-1:0] flag_n_ff;
    logic quad_strobe;

    function automatic logic [`MQR_FLAG_W-1:0] quad_slice(input logic [`MQR_NQUEUE-1:0] v,
                                                          input logic [`MQR_QUAD_W-1:0] q);
        quad_slice = v[q*`MQR_FLAG_W +: `MQR_FLAG_W];
    endfunction : quad_slice

    assign quad_strobe = direct_mode && s_strobe;

    // polled mode walks the quadrants itself, one per cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_rstn) begin
            quad_ff <= 2'h0;
            flag_oe_ff <= 1'b0;
            flag_n_ff <= 8'hff;
        end else begin
            if (quad_strobe) begin
                quad_ff <= s_addr[`MQR_QUAD_W-1:0];
                flag_oe_ff <= id_match;
            end else if (!direct_mode) begin
                quad_ff <= quad_ff + 2'h1;
                flag_oe_ff <= 1'b1;
            end
            flag_n_ff <= ~quad_slice(i_queue_almost_empty, quad_ff);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status and outputs

    assign status_w = {8'h00, 4'(fifo_level), 2'h0,
                       rd_act_ff, ovn_ff, 3'h0, rd_q_ff, 3'h0, sel_q_ff};

    assign o_rd_data = rd_data_ff;
    assign o_rd_data_oe = oe_ff;
    assign o_out_valid_n = ovn_ff;
    assign o_almost_empty_flag_n = flag_n_ff;
    assign o_almost_empty_flag_oe = flag_oe_ff;
    assign o_mem_rd_req = mem_req_ff;
    assign o_mem_rd_queue = mem_q_ff;
    assign o_prdata = prdata_ff;
    assign o_pready = pready_ff;
    assign o_pslverr = pslverr_ff;

endmodule : mqr_read_port

`default_nettype wire

// *** mqr_read_port_asserts.sv ***
`timescale 1ns/1ns
`default_nettype none
module mqr_chk #(
    parameter int DATA_W = 18
) (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_rd_addr_en,
    input wire logic i_rd_en_n,
    input wire logic i_out_en_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic [7:0] i_paddr,
    input wire logic [DATA_W-1:0] o_rd_data,
    input wire logic o_rd_data_oe,
    input wire logic o_out_valid_n,
    input wire logic [7:0] o_almost_empty_flag_n,
    input wire logic o_mem_rd_req,
    input wire logic [4:0] o_mem_rd_queue,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr
);
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rstn);
    ////////////////////////////////////////////////////////////
    // wide history: pin sync delay is not seen from here
    logic [7:0] sel_hist_ff;
    always_ff @(posedge i_clk_sys) begin
        sel_hist_ff <= i_rstn ? {sel_hist_ff[6:0], i_rd_addr_en} : 8'h00;
    end
    sequence setup_s;
        i_psel && !i_penable;
    endsequence
    ////////////////////////////////////////////////////////////
    reset_vals_a: assert property (!$past(i_rstn) |-> o_out_valid_n && !o_rd_data_oe
        && o_almost_empty_flag_n == 8'hff && !o_mem_rd_req && !o_pready)
        else $error("outputs not at reset values");
    apb_ready_a: assert property (setup_s |=> o_pready)
        else $error("no ready after setup");
    apb_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("ready held two cycles");
    apb_err_a: assert property (setup_s ##0 i_paddr > 8'h08 |=> o_pslverr && o_prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    stale_hold_a: assert property ($changed(o_rd_data) |-> !o_out_valid_n)
        else $error("data changed while marked stale");
    oe_gate_a: assert property (o_rd_data_oe |-> !$past(i_out_en_n, 3))
        else $error("data driven while disabled");
    req_en_a: assert property (o_mem_rd_req |-> !$past(i_rd_en_n, 3))
        else $error("read without read enable");
    sel_cause_a: assert property (o_mem_rd_req && $past(o_mem_rd_req)
        && o_mem_rd_queue != $past(o_mem_rd_queue) |-> |sel_hist_ff)
        else $error("queue changed without a choice");
endmodule : mqr_chk
bind mqr_read_port mqr_chk #(.DATA_W(DATA_W)) i_chk (.*);
`default_nettype wire

// *** mqr_qmem.sv ***
`timescale 1ns/1ns
`default_nettype none
module mqr_qmem (
    input wire logic i_clk_sys,
    input wire logic i_rstn,
    input wire logic i_req,
    input wire logic [4:0] i_queue,
    output logic [31:0] o_empty,
    output logic [31:0] o_almost,
    output logic o_valid,
    output logic [17:0] o_data
);
    int cnt[32];
    int seq[32];
    int bad;
    initial begin
        o_valid = 1'b0;
        o_data = 18'h0_0000;
    end
    always_comb begin
        foreach (cnt[q]) begin
            // a standing request already claims its word
            o_empty[q] = cnt[q] <= int'(i_req && i_queue == 5'(q));
            o_almost[q] = cnt[q] == 1;
        end
    end
    task automatic load(input int q, input int n);
        cnt[q] += n;
    endtask : load
    ////////////////////////////////////////////////////////////
    // word carries queue and order so the bench can trace it
    always @(posedge i_clk_sys) begin
        o_valid <= i_req && i_rstn;
        if (i_req && cnt[i_queue] > 0) begin
            o_data <= {i_queue, seq[i_queue][12:0]};
            seq[i_queue] <= seq[i_queue] + 1;
            cnt[i_queue] <= cnt[i_queue] - 1;
        end else begin
            // toggles so a stale copy never looks valid
            o_data <= ~o_data;
            bad <= bad + int'(i_req);
        end
    end
endmodule : mqr_qmem
`default_nettype wire

// *** tb_multi_queue_read_port.sv ***
`timescale 1ns/1ns
`default_nettype none
module tb_multi_queue_read_port;
    logic i_clk_sys, i_rstn, i_rd_addr_en, i_rd_en_n, i_out_en_n, i_almost_empty_strobe;
    logic i_dev_select_bit0, i_dev_select_bit1, i_dev_select_bit2, i_psel, i_penable, i_pwrite;
    logic o_rd_data_oe, o_out_valid_n, o_almost_empty_flag_oe, o_mem_rd_req, i_mem_rd_valid;
    logic o_pready, o_pslverr, err;
    logic [4:0] o_mem_rd_queue;
    logic [7:0] i_rd_queue_addr, i_paddr, o_almost_empty_flag_n;
    logic [17:0] o_rd_data, i_mem_rd_data, last_w;
    logic [17:0] seen[$], exp_w[$];
    logic [31:0] i_pwdata, o_prdata, i_queue_empty, i_queue_almost_empty, rd;
    int errors, comparisons;
    mqr_read_port i_dut (.*);
    mqr_qmem i_mem (
        .i_clk_sys(i_clk_sys),
        .i_rstn(i_rstn),
        .i_req(o_mem_rd_req),
        .i_queue(o_mem_rd_queue),
        .o_empty(i_queue_empty),
        .o_almost(i_queue_almost_empty),
        .o_valid(i_mem_rd_valid),
        .o_data(i_mem_rd_data)
    );
    ////////////////////////////////////////////////////////////
    task automatic cyc(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask : cyc
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", what, exp, got);
        end
    endtask : chk
    task automatic print_verdict();
        if (errors == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        cyc(1);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= a;
        i_pwdata <= d;
        cyc(1);
        i_penable <= 1'b1;
        do cyc(1); while (o_pready !== 1'b1);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask : apb
    // one-cycle pin pulse, then the spacing the controller owes
    task automatic pin(input logic en, input logic es, input logic [7:0] a);
        cyc(1);
        i_rd_addr_en <= en;
        i_almost_empty_strobe <= es;
        i_rd_queue_addr <= a;
        cyc(1);
        i_rd_addr_en <= 1'b0;
        i_almost_empty_strobe <= 1'b0;
        cyc(2);
    endtask : pin
    task automatic add_exp(input logic [4:0] q, input int a, input int b);
        for (int i = a; i < b; i++) exp_w.push_back({q, i[12:0]});
    endtask : add_exp
    task automatic cmp_seen();
        chk("word count", exp_w.size(), seen.size());
        foreach (exp_w[i]) chk("word", exp_w[i], seen[i]);
        exp_w.delete();
        seen.delete();
    endtask : cmp_seen
    ////////////////////////////////////////////////////////////
    initial begin
        i_clk_sys = 1'b0;
        forever #5 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys) if (o_rd_data !== last_w) begin
        seen.push_back(o_rd_data);
        last_w = o_rd_data;
    end
    initial begin
        cyc(5000);
        errors++;
        print_verdict();
    end
    initial begin
        {i_rstn, i_rd_addr_en, i_almost_empty_strobe, i_psel, i_penable, i_pwrite} = 6'h00;
        {i_rd_en_n, i_out_en_n, i_rd_queue_addr, i_paddr, i_pwdata} = {2'b10, 48'h0};
        {i_dev_select_bit2, i_dev_select_bit1, i_dev_select_bit0} = 3'b101;
        cyc(3);
        i_rstn <= 1'b1;
        chk("valid_n", 1, o_out_valid_n);
        chk("flag_n", 8'hff, o_almost_empty_flag_n);
        apb(0, 8'h00, 0);
        chk("ctrl", 32'h0000_0003, rd);
        apb(1, 8'h00, 32'h0000_0002);
        apb(0, 8'h00, 0);
        chk("ctrl", 32'h0000_0002, rd);
        apb(1, 8'h00, 32'h0000_0003);
        apb(0, 8'h0c, 0);
        chk("slverr", 1, err);
        // switch queues while the old one still has words
        i_mem.load(3, 6);
        i_mem.load(5, 3);
        seen.delete();
        i_rd_en_n <= 1'b0;
        pin(1, 0, 8'ha3);
        pin(1, 0, 8'ha5);
        cyc(30);
        add_exp(3, 0, 4);
        add_exp(5, 0, 3);
        cmp_seen();
        i_mem.load(3, 20);
        pin(1, 0, 8'ha3);
        pin(1, 0, 8'ha7);
        cyc(30);
        add_exp(3, 4, 8);
        cmp_seen();
        chk("empty reads", 0, i_mem.bad);
        chk("valid_n", 1, o_out_valid_n);
        apb(0, 8'h04, 0);
        chk("status", 32'h0003_0707, rd);
        apb(0, 8'h08, 0);
        chk("wcount", 32'h0000_000b, rd);
        i_mem.load(9, 2);
        pin(1, 0, 8'h49);
        cyc(20);
        chk("foreign id", 2, i_mem.cnt[9]);
        i_out_en_n <= 1'b1;
        pin(1, 0, 8'ha9);
        cyc(20);
        chk("oe", 0, o_rd_data_oe);
        add_exp(9, 0, 2);
        cmp_seen();
        i_out_en_n <= 1'b0;
        i_rd_en_n <= 1'b1;
        cyc(6);
        chk("oe", 1, o_rd_data_oe);
        for (int k = 0; k < 4; k++) i_mem.load(k * 9, 1);
        for (int k = 0; k < 4; k++) begin
            pin(0, 1, {6'b101000, k[1:0]});
            cyc(4);
            chk("flag_n", {24'h0, ~(8'h01 << k)}, o_almost_empty_flag_n);
        end
        chk("flag_oe", 1, o_almost_empty_flag_oe);
        // read gate off: queue 9 keeps its word
        apb(1, 8'h00, 32'h0000_0001);
        i_rd_en_n <= 1'b0;
        cyc(20);
        chk("gated reads", 1, i_mem.cnt[9]);
        print_verdict();
    end
endmodule : tb_multi_queue_read_port
`default_nettype wire
